// [opc_top.sv]
// Summary of operation
// - amplifier control at ff60, reset 00, bit7 amp_zero_noninverting_in, bit3 amp_one_noninverting_in, rest zero
// - amp_zero_noninverting_in enable bit zero stops amplifier 0, one runs it
// - amp_one_noninverting_in enable bit zero stops amplifier 1, one runs it
// - amplifier control accepts single-bit and whole-byte writes
// - analog pin select resets to 00, all pins analog
// - each pin select bit: 0 analog, 1 digital, bit writable
// - pin select writes add a wait cycle; never write with clock stopped
// - three-bit channel code, 0..4; code 1 carries pin 1 or amp_zero_noninverting_in output
// - channel select at ff0e resets to 00, channel 0
// - direction at ff22 resets ff; 0 output, 1 input
// - amplifier pins in output direction do not serve the amplifier
// - pins 0 and 2: convert, plain analog, or amplifier input
// - pin 1 analog, amp_zero_noninverting_in on, channel 1: converter samples amp_zero_noninverting_in output
// - pin 1 analog, amp_zero_noninverting_in on, other channel: pin carries amp_zero_noninverting_in output
module opc_top
   import opc_pkg::*;
#(
   parameter int WAIT_CYC = OPC_WAIT_CYC
)(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // processor memory access
   input  wire logic [15:0] addr,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic        bit_wr,
   input  wire logic [2:0]  bit_sel,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata,
   output logic             rd_hit,
   output logic             wait_req,
   // amplifier controls
   output logic             amp_zero_run,
   output logic             amp_one_run,
   output logic             amp_zero_to_conv,
   output logic             amp_zero_pins_ok,
   output logic             amp_one_pins_ok,
   // pin settings
   output logic      [7:0]  digital_sel,
   output logic      [7:0]  out_buf_en,
   output logic      [2:0]  conv_channel,
   output opc_role_t [2:0]  pin_role
);
   opc_cfg_if cfg ();
   logic [7:0] wait_cnt;
   logic       apin_wr;

   opc_regs u_regs (
      .mclk    (mclk),
      .reset   (reset),
      .addr    (addr),
      .wr_en   (wr_en && !wait_req),
      .bit_wr  (bit_wr),
      .bit_sel (bit_sel),
      .wdata   (wdata),
      .cfg     (cfg)
   );

   opc_decode u_dec (
      .cfg  (cfg),
      .role (pin_role)
   );

   // pin select write is held off by wait cycles, then taken in the cycle after the last one
   assign apin_wr = wr_en && addr == OPC_ADDR_APIN;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wait_cnt <= 8'h00;
      end else if (apin_wr && wait_cnt == 8'h00) begin
         wait_cnt <= 8'(WAIT_CYC);
      end else if (wait_cnt != 8'h00) begin
         wait_cnt <= wait_cnt - 8'h01;
      end
   end
   // count 1 is the cycle in which the held write is taken
   assign wait_req = apin_wr && wait_cnt != 8'h01;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata  <= 8'h00;
         rd_hit <= 1'b0;
      end else begin
         rd_hit <= rd_en;
         unique case (addr)
            OPC_ADDR_AMP:  rdata <= cfg.amp_ctl;
            OPC_ADDR_APIN: rdata <= cfg.apin;
            OPC_ADDR_CHAN: rdata <= {5'h00, cfg.chan};
            OPC_ADDR_DIR:  rdata <= cfg.dir;
            default: begin
               rdata  <= 8'h00;
               rd_hit <= 1'b0;
            end
         endcase
      end
   end

   assign amp_zero_run     = cfg.amp_ctl[OPC_AMP_ZERO_NONINVERTING_IN_BIT];
   assign amp_one_run      = cfg.amp_ctl[OPC_AMP_ONE_NONINVERTING_IN_BIT];
   assign amp_zero_to_conv = amp_zero_run && pin_role[1] == OPC_ROLE_AMP_CONV;
   // amplifier pins only connect when analog and input direction
   assign amp_zero_pins_ok = &(cfg.dir[2:0] & ~cfg.apin[2:0]);
   assign amp_one_pins_ok  = &(cfg.dir[7:5] & ~cfg.apin[7:5]);
   assign digital_sel      = cfg.apin;
   assign out_buf_en       = ~cfg.dir;
   assign conv_channel     = cfg.chan;
endmodule

// [opc_pkg.sv]
package opc_pkg;
   localparam logic [15:0] OPC_ADDR_CHAN  = 16'hff0e;
   localparam logic [15:0] OPC_ADDR_DIR   = 16'hff22;
   localparam logic [15:0] OPC_ADDR_AMP   = 16'hff60;
   localparam logic [15:0] OPC_ADDR_APIN  = 16'hff97;
   localparam logic [7:0]  OPC_RST_CHAN   = 8'h00;
   localparam logic [7:0]  OPC_RST_DIR    = 8'hff;
   localparam logic [7:0]  OPC_RST_AMP    = 8'h00;
   localparam logic [7:0]  OPC_RST_APIN   = 8'h00;
   localparam int          OPC_AMP_ZERO_NONINVERTING_IN_BIT   = 7;
   localparam int          OPC_AMP_ONE_NONINVERTING_IN_BIT   = 3;
   localparam logic [7:0]  OPC_AMP_MASK   = 8'h88;
   localparam logic [7:0]  OPC_CHAN_MASK  = 8'h07;
   localparam int          OPC_WAIT_CYC   = 1;
   // pin roles
   typedef enum logic [3:0] {
      OPC_ROLE_ANALOG   = 4'h0,
      OPC_ROLE_CONVERT  = 4'h1,
      OPC_ROLE_AMP_IN   = 4'h2,
      OPC_ROLE_AMP_OUT  = 4'h3,
      OPC_ROLE_AMP_CONV = 4'h4,
      OPC_ROLE_DIG_IN   = 4'h5,
      OPC_ROLE_DIG_OUT  = 4'h6,
      OPC_ROLE_UNDEF    = 4'h7
   } opc_role_t;
endpackage

// [opc_cfg_if.sv]
interface opc_cfg_if;
   import opc_pkg::*;
   logic [7:0] amp_ctl;
   logic [7:0] apin;
   logic [2:0] chan;
   logic [7:0] dir;
   modport regs (output amp_ctl, output apin, output chan, output dir);
   modport dec  (input amp_ctl, input apin, input chan, input dir);
endinterface

// [opc_regs.sv]
module opc_regs
   import opc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // processor access
   input  wire logic [15:0] addr,
   input  wire logic        wr_en,
   input  wire logic        bit_wr,
   input  wire logic [2:0]  bit_sel,
   input  wire logic [7:0]  wdata,
   // held values
   opc_cfg_if.regs          cfg
);
   logic [7:0] amp_q;
   logic [7:0] apin_q;
   logic [7:0] chan_q;
   logic [7:0] dir_q;

   // bit access rewrites one bit of the current value, byte access replaces it
   function automatic logic [7:0] merge(input logic [7:0] old);
      logic [7:0] v;
      v = old;
      if (bit_wr) begin
         v[bit_sel] = wdata[0];
      end else begin
         v = wdata;
      end
      return v;
   endfunction

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         amp_q <= OPC_RST_AMP;
      end else if (wr_en && addr == OPC_ADDR_AMP) begin
         amp_q <= merge(amp_q) & OPC_AMP_MASK;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         apin_q <= OPC_RST_APIN;
      end else if (wr_en && addr == OPC_ADDR_APIN) begin
         apin_q <= merge(apin_q);
      end
   end

   // illegal codes are kept as written; only the three field bits exist
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan_q <= OPC_RST_CHAN;
      end else if (wr_en && addr == OPC_ADDR_CHAN) begin
         chan_q <= merge(chan_q) & OPC_CHAN_MASK;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         dir_q <= OPC_RST_DIR;
      end else if (wr_en && addr == OPC_ADDR_DIR) begin
         dir_q <= merge(dir_q);
      end
   end

   assign cfg.amp_ctl = amp_q;
   assign cfg.apin    = apin_q;
   assign cfg.chan    = chan_q[2:0];
   assign cfg.dir     = dir_q;
endmodule

// [opc_decode.sv]
module opc_decode
   import opc_pkg::*;
(
   // settings
   opc_cfg_if.dec          cfg,
   // decoded roles
   output opc_role_t [2:0] role
);
   logic amp_zero_noninverting_in_on;
   assign amp_zero_noninverting_in_on = cfg.amp_ctl[OPC_AMP_ZERO_NONINVERTING_IN_BIT];

   // combinations the software must avoid decode to undefined; no checking
   genvar i;
   for (i = 0; i < 3; i++) begin : g_pin
      logic sel;
      assign sel = (cfg.chan == 3'(i));
      always_comb begin
         if (!cfg.dir[i]) begin
            role[i] = cfg.apin[i] ? OPC_ROLE_DIG_OUT : OPC_ROLE_UNDEF;
            if (cfg.apin[i] && (sel || (i == 1 && amp_zero_noninverting_in_on))) begin
               role[i] = OPC_ROLE_UNDEF;
            end
         end else if (cfg.apin[i]) begin
            role[i] = (sel || (i == 1 && amp_zero_noninverting_in_on)) ? OPC_ROLE_UNDEF
                                                   : OPC_ROLE_DIG_IN;
         end else if (i == 1) begin
            if (amp_zero_noninverting_in_on) begin
               role[i] = sel ? OPC_ROLE_AMP_CONV : OPC_ROLE_AMP_OUT;
            end else begin
               role[i] = sel ? OPC_ROLE_CONVERT : OPC_ROLE_ANALOG;
            end
         end else begin
            if (amp_zero_noninverting_in_on) begin
               role[i] = sel ? OPC_ROLE_UNDEF : OPC_ROLE_AMP_IN;
            end else begin
               role[i] = sel ? OPC_ROLE_CONVERT : OPC_ROLE_ANALOG;
            end
         end
      end
   end
endmodule

// [opc_top_assertions.sv]
module opc_chk
   import opc_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // access
   input wire logic [15:0] addr,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic        bit_wr,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        rd_hit,
   input wire logic        wait_req,
   // settings out
   input wire logic        amp_zero_run,
   input wire logic        amp_one_run,
   input wire logic        amp_zero_to_conv,
   input wire logic        amp_zero_pins_ok,
   input wire logic [7:0]  digital_sel,
   input wire logic [7:0]  out_buf_en,
   input wire logic [2:0]  conv_channel
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic [7:0] wd_q;
   wire        byte_wr = wr_en && !wait_req && !bit_wr;
   always_ff @(posedge mclk) wd_q <= wdata;
   sequence s_one_wait;
      wait_req ##1 !wait_req;
   endsequence
   a_amp_run: assert property (byte_wr && addr == OPC_ADDR_AMP |=>
      amp_zero_run == wd_q[7] && amp_one_run == wd_q[3]) else $error("amp enable mismatch");
   a_pin_sel: assert property (byte_wr && addr == OPC_ADDR_APIN |=>
      digital_sel == wd_q) else $error("pin select not stored");
   a_wait_cause: assert property (wait_req |-> wr_en && addr == OPC_ADDR_APIN ##1
      $stable(digital_sel)) else $error("pin select taken during wait");
   a_wait_once: assert property ($rose(wr_en) && addr == OPC_ADDR_APIN |-> s_one_wait)
      else $error("pin select wait not one cycle");
   a_dir_buf: assert property (byte_wr && addr == OPC_ADDR_DIR |=>
      out_buf_en == ~wd_q) else $error("direction not applied");
   a_chan_keep: assert property (byte_wr && addr == OPC_ADDR_CHAN |=>
      conv_channel == wd_q[2:0]) else $error("channel not stored");
   a_amp_conv: assert property (amp_zero_to_conv == (amp_zero_run && !digital_sel[1]
      && !out_buf_en[1] && conv_channel == 3'h1)) else $error("amp_zero_noninverting_in conversion route");
   a_pins_ok: assert property (amp_zero_pins_ok == (out_buf_en[2:0] == 3'h0
      && digital_sel[2:0] == 3'h0)) else $error("amp_zero_noninverting_in pin usability");
   a_dir_read: assert property (rd_en && addr == OPC_ADDR_DIR |=>
      rd_hit && rdata == ~$past(out_buf_en)) else $error("direction readback");
endmodule
bind opc_top opc_chk chk_u (.mclk, .reset, .addr, .wr_en, .rd_en, .bit_wr, .wdata, .rdata,
   .rd_hit, .wait_req, .amp_zero_run, .amp_one_run, .amp_zero_to_conv, .amp_zero_pins_ok,
   .digital_sel, .out_buf_en, .conv_channel);

// [tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import opc_pkg::*;
   logic mclk = 0, reset = 1, wr_en = 0, rd_en = 0, bit_wr = 0, rd_pend = 0;
   logic [15:0] addr = '0;
   logic [2:0] bit_sel = '0, conv_channel;
   logic [7:0] wdata = '0, rdata, digital_sel, out_buf_en, v;
   logic rd_hit, wait_req, amp_zero_run, amp_one_run, amp_zero_to_conv;
   logic amp_zero_pins_ok, amp_one_pins_ok;
   opc_role_t [2:0] pin_role;
   logic [8:0] exp_q[$];
   int error_cnt = 0, num_checks = 0, seed = 5;
   opc_top dut_u (.*);
   always #20 mclk = ~mclk;
   task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic role(int p, opc_role_t e);
      chk("role", e, pin_role[p]);
   endtask
   // called at a falling edge; request held until taken
   task automatic wr(logic [15:0] a, logic [7:0] d, logic b = 0, logic [2:0] s = 0);
      addr = a;
      wdata = d;
      bit_wr = b;
      bit_sel = s;
      wr_en = 1;
      #1;
      while (wait_req) @(negedge mclk);
      @(negedge mclk);
      wr_en = 0;
      @(negedge mclk);
   endtask
   task automatic rd(logic [15:0] a, logic [8:0] e);
      addr = a;
      rd_en = 1;
      exp_q.push_back(e);
      @(negedge mclk);
      rd_en = 0;
      @(negedge mclk);
   endtask
   always @(posedge mclk) rd_pend <= rd_en;
   always @(negedge mclk) if (rd_pend) chk("read", exp_q.pop_front(), {rd_hit, rdata});
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #80000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(negedge mclk);
      reset = 0;
      rd(OPC_ADDR_CHAN, 9'h100);
      rd(OPC_ADDR_DIR, 9'h1ff);
      rd(OPC_ADDR_AMP, 9'h100);
      rd(OPC_ADDR_APIN, 9'h100);
      rd({8'h01, 8'($random(seed))}, 9'h000);
      $display("reset values done");
      v = 8'($random(seed));
      wr(OPC_ADDR_AMP, v);
      rd(OPC_ADDR_AMP, {1'b1, v & OPC_AMP_MASK});
      chk("amp_zero_noninverting_in", v[7], amp_zero_run);
      chk("amp_one_noninverting_in", v[3], amp_one_run);
      wr(OPC_ADDR_AMP, 8'h01, 1, 3'h7);
      wr(OPC_ADDR_AMP, 8'h00, 1, 3'h3);
      rd(OPC_ADDR_AMP, 9'h180);
      v = 8'($random(seed));
      wr(OPC_ADDR_APIN, v);
      chk("digsel", v, digital_sel);
      wr(OPC_ADDR_APIN, 8'h01, 1, 3'h6);
      rd(OPC_ADDR_APIN, {1'b1, v | 8'h40});
      v = 8'($random(seed));
      wr(OPC_ADDR_DIR, v);
      chk("outbuf", 8'(~v), out_buf_en);
      for (int c = 0; c < 5; c++) begin
         wr(OPC_ADDR_CHAN, 8'(c));
         rd(OPC_ADDR_CHAN, 9'h100 | 9'(c));
      end
      $display("register access done");
      wr(OPC_ADDR_DIR, 8'hff);
      wr(OPC_ADDR_APIN, 8'h00);
      wr(OPC_ADDR_AMP, 8'h80);
      wr(OPC_ADDR_CHAN, 8'h01);
      chk("conv", 1, amp_zero_to_conv);
      role(1, OPC_ROLE_AMP_CONV);
      role(0, OPC_ROLE_AMP_IN);
      chk("ok1", 1, amp_one_pins_ok);
      wr(OPC_ADDR_CHAN, 8'h03);
      role(1, OPC_ROLE_AMP_OUT);
      wr(OPC_ADDR_CHAN, 8'h00);
      role(0, OPC_ROLE_UNDEF);
      wr(OPC_ADDR_AMP, 8'h00);
      role(0, OPC_ROLE_CONVERT);
      role(2, OPC_ROLE_ANALOG);
      wr(OPC_ADDR_DIR, 8'h1e);
      chk("oks", 0, {amp_zero_pins_ok, amp_one_pins_ok});
      wr(OPC_ADDR_APIN, 8'h04);
      wr(OPC_ADDR_DIR, 8'hff);
      role(2, OPC_ROLE_DIG_IN);
      wr(OPC_ADDR_DIR, 8'hfb);
      role(2, OPC_ROLE_DIG_OUT);
      $display("pin roles done");
      report_and_stop;
   end
endmodule
